// >>> hw/rci_interp.sv
// Remote command interpreter: register port, command execution, terminal output
`timescale 1ns/1ns
`default_nettype none
`include "rci_params.svh"
module rci_interp #(
  parameter int TICK_CYC = `RCI_TICK_CYC
) (
  input wire logic ref_clk, // 250 MHz
  input wire logic sys_rst, // Synchronous, active high
  input wire rci_pkg::rci_bus_s bus, // Register port request
  output var logic [31:0] rd_data, // Read data, cycle after rd
  input wire logic [3:0] baud_code_pin, // Front-panel baud selection
  input wire logic [3:0] data_bits_pin, // Front-panel data-bit setting
  input wire logic print_event_pin, // Print event selected
  input wire logic alarm_msg_req, // Alarm/status/note message pending
  input wire logic prog_suspended, // Program stopped by a stop
  input wire logic prog_modified, // A line changed since the stop
  input wire logic prog_finished, // Program reached its end
  output var logic [7:0] tx_char, // Character to the terminal
  output logic tx_valid, // Character offered
  input wire logic tx_ready, // Serial side takes it
  output var rci_pkg::rci_ctl_s ctl, // One-cycle action pulses
  output var logic [2:0] err_code, // Code of last error
  output var logic tx_b8zs, // Transmit line code B8ZS
  output logic rx_b8zs, // Receive decoder mode
  output var logic display_freeze, // Result display held
  output var rci_pkg::rci_ins_e logic_ins, // Logic error insert mode
  output var rci_pkg::rci_ins_e viol_ins, // Violation insert mode
  output var logic [15:0] burst_ms, // Burst duration, ms
  output var logic [6:0] propagation_velocity // Velocity, hundredths
);
  import rci_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [8:0] pin_meta_ff;
  logic [8:0] pin_sync_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta_ff <= 9'h000;
      pin_sync_ff <= 9'h000;
    end else begin
      pin_meta_ff <= {print_event_pin, data_bits_pin, baud_code_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire [3:0] baud_s = pin_sync_ff[3:0];
  wire [3:0] dbits_s = pin_sync_ff[7:4];
  wire print_event_s = pin_sync_ff[8];

  // ************************************************************
  // Register port decode
  // ************************************************************
  logic [15:0] arg_a_ff;
  logic [15:0] arg_b_ff;
  logic [7:0] sep_ff;
  wire wr_cmd = bus.wr && (bus.addr == `RCI_OFF_CMD);
  wire wr_arga = bus.wr && (bus.addr == `RCI_OFF_ARGA);
  wire wr_argb = bus.wr && (bus.addr == `RCI_OFF_ARGB);
  wire wr_sep = bus.wr && (bus.addr == `RCI_OFF_SEP);
  wire is_set = bus.wdata[`RCI_CMD_SET_BIT];
  rci_op_e op;
  assign op = rci_op_e'(bus.wdata[4:0]);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arg_a_ff <= 16'h0000;
      arg_b_ff <= 16'h0000;
      sep_ff <= 8'h00;
    end else begin
      if (wr_arga) arg_a_ff <= bus.wdata[15:0];
      if (wr_argb) arg_b_ff <= bus.wdata[15:0];
      if (wr_sep) sep_ff <= bus.wdata[7:0];
    end
  end

  // ************************************************************
  // Parameter checks
  // ************************************************************
  wire sep_ok = (sep_ff == 8'h3a) || (sep_ff == 8'h2c) || (sep_ff == 8'h2e) ||
    (sep_ff == 8'h3b) || (sep_ff == 8'h2f) || (sep_ff == 8'h2d);
  wire time_ok = sep_ok && (arg_a_ff < 16'h0018) && (arg_b_ff < 16'h003c);
  wire date_ok = sep_ok && (arg_a_ff >= 16'h0001) && (arg_a_ff <= 16'h001f) &&
    (arg_b_ff >= 16'h0001) && (arg_b_ff <= 16'h000c);
  // Fraction arrives as four decimal digits; the fourth is dropped
  wire [3:0] fd1 = arg_b_ff[15:12];
  wire [3:0] fd2 = arg_b_ff[11:8];
  wire [3:0] fd3 = arg_b_ff[7:4];
  wire bcd_ok = (fd1 < 4'ha) && (fd2 < 4'ha) && (fd3 < 4'ha);
  wire [15:0] raw_ms = 16'(arg_a_ff[3:0]) * 16'd1000 + 16'(fd1) * 16'd100 +
    16'(fd2) * 16'd10 + 16'(fd3);
  wire burst_rng = (arg_a_ff <= 16'h0005) && (raw_ms >= `RCI_BURST_MIN) &&
    (raw_ms <= `RCI_BURST_MAX);

  function automatic logic [15:0] rci_quant(input logic [15:0] v);
    logic [15:0] q;
    q = v;
    if (v <= 16'd200) begin
      q = v - v % 16'd25;
    end else if (v < 16'd250) begin
      q = 16'd200;
    end else if (v <= 16'd500) begin
      q = v - v % 16'd50;
    end else if (v < 16'd600) begin
      q = 16'd500;
    end else if (v <= 16'd1500) begin
      q = v - v % 16'd100;
    end else if (v < 16'd2000) begin
      q = 16'd1500;
    end else begin
      q = v - v % 16'd500;
    end
    return q;
  endfunction : rci_quant
  wire [15:0] quant_ms = rci_quant(raw_ms);

  wire [3:0] gauge = arg_b_ff[3:0];
  wire gauge_ok = (gauge == 4'h2) || (gauge == 4'h4) || (gauge == 4'h6);
  wire cab_user = arg_a_ff[2:0] == 3'h3;
  wire cab_dflt = arg_a_ff[2:0] == 3'h4;
  wire cable_ok = (arg_a_ff[15:3] == 13'h0000) &&
    ((arg_a_ff[2:0] <= 3'h3 && gauge_ok) || cab_dflt);
  wire resume_ok = prog_suspended && !prog_modified && !prog_finished;
  wire arg_bit_ok = arg_a_ff[15:1] == 15'h0000;
  wire ins_ok = arg_a_ff[15:2] == 14'h0000;

  // ************************************************************
  // Command verdict
  // ************************************************************
  rci_tx_e tx_st_ff;
  wire tx_busy = tx_st_ff == TX_SEND;
  rci_err_e verdict;
  always_comb begin
    verdict = ERR_NONE;
    case (op)
      OP_NOP, OP_CLRFIFO, OP_CONTROLS: verdict = ERR_NONE;
      OP_ALARM, OP_CODE, OP_DISHOLD: verdict = (is_set && !arg_bit_ok) ? ERR_PARAM : ERR_NONE;
      OP_BAUD, OP_DBITS: verdict = is_set ? ERR_NOEXEC : ERR_NONE;
      OP_BEEP, OP_CLS: verdict = tx_busy ? ERR_BUSY : ERR_NONE;
      OP_BURST: begin
        if (is_set && !bcd_ok) verdict = ERR_PARAM;
        else if (is_set && !burst_rng) verdict = ERR_RANGE;
      end
      OP_CABLE: verdict = (is_set && !cable_ok) ? ERR_PARAM : ERR_NONE;
      OP_CLOCK: verdict = (is_set && !time_ok) ? ERR_PARAM : ERR_NONE;
      OP_DATE: verdict = (is_set && !date_ok) ? ERR_PARAM : ERR_NONE;
      OP_RESUME: verdict = resume_ok ? ERR_NONE : ERR_RESUME;
      OP_ERRINS: verdict = (is_set && !ins_ok) ? ERR_PARAM : ERR_NONE;
      OP_VEL: verdict = (is_set && arg_a_ff > 16'd99) ? ERR_PARAM : ERR_NONE;
      default: verdict = ERR_UNKNOWN;
    endcase
  end
  // Only an accepted set form touches a setting
  wire exec_ok = wr_cmd && (verdict == ERR_NONE);
  wire do_set = exec_ok && is_set;
  wire set_ins = do_set && (op == OP_ERRINS);
  wire [1:0] ins_arg = arg_a_ff[1:0];

  // ************************************************************
  // Settings
  // ************************************************************
  logic alarm_en_ff;
  logic [2:0] cab_type_ff;
  logic [3:0] cab_gauge_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_en_ff <= 1'b0;
      tx_b8zs <= 1'b0;
      display_freeze <= 1'b0;
      burst_ms <= `RCI_RST_BURST;
      logic_ins <= INS_OFF;
      viol_ins <= INS_OFF;
      cab_type_ff <= 3'h4;
      cab_gauge_ff <= 4'h2;
      propagation_velocity <= `RCI_VEL_DEFAULT;
    end else if (do_set) begin
      case (op)
        OP_ALARM: alarm_en_ff <= arg_a_ff[0];
        OP_CODE: tx_b8zs <= arg_a_ff[0];
        OP_DISHOLD: display_freeze <= arg_a_ff[0];
        OP_BURST: burst_ms <= quant_ms;
        OP_CABLE: begin
          cab_type_ff <= arg_a_ff[2:0];
          cab_gauge_ff <= cab_dflt ? 4'h2 : gauge;
          if (cab_dflt) propagation_velocity <= `RCI_VEL_DEFAULT;
        end
        OP_VEL: propagation_velocity <= arg_a_ff[6:0];
        OP_ERRINS: begin
          if (arg_b_ff[0]) viol_ins <= rci_ins_e'(ins_arg);
          else logic_ins <= rci_ins_e'(ins_arg);
          if (ins_arg == INS_SINGLE) burst_ms <= 16'h0000;
        end
        default: ;
      endcase
    end
  end
  // The decoder handles both codes whatever the transmitter uses
  assign rx_b8zs = 1'b1;

  // ************************************************************
  // Time of day and date
  // ************************************************************
  logic [31:0] tick_cnt_ff;
  logic [5:0] sec_ff;
  logic [5:0] min_ff;
  logic [4:0] hr_ff;
  logic [4:0] day_ff;
  logic [3:0] mon_ff;
  wire set_clock = do_set && (op == OP_CLOCK);
  wire sec_tick = tick_cnt_ff == 32'(TICK_CYC - 1);
  wire min_wrap = sec_tick && (sec_ff == 6'd59);
  wire hr_wrap = min_wrap && (min_ff == 6'd59);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_cnt_ff <= 32'h0000_0000;
      sec_ff <= 6'h00;
      min_ff <= 6'h00;
      hr_ff <= 5'h00;
    end else if (set_clock) begin
      tick_cnt_ff <= 32'h0000_0000;
      sec_ff <= 6'h00;
      min_ff <= arg_b_ff[5:0];
      hr_ff <= arg_a_ff[4:0];
    end else begin
      tick_cnt_ff <= sec_tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      if (sec_tick) sec_ff <= min_wrap ? 6'h00 : sec_ff + 6'h01;
      if (min_wrap) min_ff <= hr_wrap ? 6'h00 : min_ff + 6'h01;
      if (hr_wrap) hr_ff <= (hr_ff == 5'd23) ? 5'h00 : hr_ff + 5'h01;
    end
  end
  // Date does not roll at midnight; software rewrites it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      day_ff <= 5'h01;
      mon_ff <= 4'h1;
    end else if (do_set && (op == OP_DATE)) begin
      day_ff <= arg_a_ff[4:0];
      mon_ff <= arg_b_ff[3:0];
    end
  end

  // ************************************************************
  // Terminal output: beep and screen clear
  // ************************************************************
  logic [5:0] tx_cnt_ff;
  wire tx_take = tx_valid && tx_ready;
  assign tx_valid = tx_st_ff == TX_SEND;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_st_ff <= TX_IDLE;
      tx_cnt_ff <= 6'h00;
      tx_char <= 8'h00;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          if (exec_ok && (op == OP_BEEP)) begin
            tx_st_ff <= TX_SEND;
            tx_cnt_ff <= 6'h01;
            tx_char <= `RCI_CHR_BEL;
          end else if (exec_ok && (op == OP_CLS)) begin
            tx_st_ff <= TX_SEND;
            tx_cnt_ff <= `RCI_CLS_COUNT;
            tx_char <= `RCI_CHR_CR;
          end
        end
        TX_SEND: begin
          if (tx_take) begin
            tx_cnt_ff <= tx_cnt_ff - 6'h01;
            if (tx_cnt_ff == 6'h01) tx_st_ff <= TX_IDLE;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Action pulses and error report
  // ************************************************************
  rci_ctl_s nxt_ctl;
  assign nxt_ctl.alarm_print = alarm_msg_req && alarm_en_ff && print_event_s;
  assign nxt_ctl.fifo_clear = exec_ok && (op == OP_CLRFIFO);
  assign nxt_ctl.resume = exec_ok && (op == OP_RESUME);
  assign nxt_ctl.controls_print = exec_ok && (op == OP_CONTROLS);
  assign nxt_ctl.err = wr_cmd && (verdict != ERR_NONE);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl <= '0;
      err_code <= 3'h0;
    end else begin
      ctl <= nxt_ctl;
      if (nxt_ctl.err) err_code <= verdict;
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  wire [31:0] stat_w = {24'h0, tx_busy, 4'h0, err_code};
  wire [31:0] sets_w = {8'h0, dbits_s, baud_s, 4'h0, viol_ins, logic_ins,
    4'h0, print_event_s, display_freeze, tx_b8zs, alarm_en_ff};
  wire [31:0] time_w = {11'h0, hr_ff, 2'h0, min_ff, 2'h0, sec_ff};
  wire [31:0] date_w = {19'h0, day_ff, 4'h0, mon_ff};
  wire [31:0] cab_w = {9'h0, propagation_velocity, 4'h0, cab_gauge_ff, 5'h0, cab_type_ff};
  wire [31:0] rd_mux = (bus.addr == `RCI_OFF_ARGA) ? {16'h0, arg_a_ff} :
    (bus.addr == `RCI_OFF_ARGB) ? {16'h0, arg_b_ff} :
    (bus.addr == `RCI_OFF_SEP) ? {24'h0, sep_ff} :
    (bus.addr == `RCI_OFF_STAT) ? stat_w :
    (bus.addr == `RCI_OFF_SETS) ? sets_w :
    (bus.addr == `RCI_OFF_BURST) ? {16'h0, burst_ms} :
    (bus.addr == `RCI_OFF_TIME) ? time_w :
    (bus.addr == `RCI_OFF_DATE) ? date_w :
    (bus.addr == `RCI_OFF_CABLE) ? cab_w : 32'h0000_0000;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) rd_data <= 32'h0000_0000;
    else rd_data <= bus.rd ? rd_mux : 32'h0000_0000;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_alarm_gate: assert property (ctl.alarm_print |->
    $past(alarm_en_ff) && $past(print_event_s) && $past(alarm_msg_req))
    else $error("alarm print without enable and print event");
  a_baud_refused: assert property (wr_cmd && is_set && (op == OP_BAUD) |=>
    ctl.err && (err_code == ERR_NOEXEC) && $stable(sets_w[23:16]))
    else $error("baud set was not refused");
  a_dbits_refused: assert property (wr_cmd && is_set && (op == OP_DBITS) |=>
    ctl.err && (err_code == ERR_NOEXEC) && $stable(sets_w[23:16]))
    else $error("data bit set was not refused");
  a_beep_once: assert property (exec_ok && (op == OP_BEEP) |=>
    tx_valid && (tx_char == 8'h07) && (tx_cnt_ff == 6'h01))
    else $error("beep is not a single bell");
  a_single_zero: assert property (set_ins && (ins_arg == INS_SINGLE) |=>
    burst_ms == 16'h0000)
    else $error("single insertion left burst nonzero");
  a_burst_step: assert property (burst_ms == 16'h0000 ||
    (burst_ms <= 16'd200 && burst_ms % 16'd25 == 16'h0000) ||
    (burst_ms >= 16'd250 && burst_ms <= 16'd500 && burst_ms % 16'd50 == 16'h0000) ||
    (burst_ms >= 16'd600 && burst_ms <= 16'd1500 && burst_ms % 16'd100 == 16'h0000) ||
    (burst_ms >= 16'd2000 && burst_ms <= 16'd5000 && burst_ms % 16'd500 == 16'h0000))
    else $error("burst duration off step");
  a_burst_range: assert property (wr_cmd && is_set && (op == OP_BURST) && bcd_ok &&
    !burst_rng |=> (err_code == ERR_RANGE) && $stable(burst_ms))
    else $error("out of range burst accepted");
  a_fifo_clear: assert property (exec_ok && (op == OP_CLRFIFO) |=>
    ctl.fifo_clear ##1 !ctl.fifo_clear)
    else $error("fifo clear pulse wrong");
  a_sec_zero: assert property (set_clock |=> (sec_ff == 6'h00) &&
    (hr_ff == $past(arg_a_ff[4:0])) && (min_ff == $past(arg_b_ff[5:0])))
    else $error("time set did not zero seconds");
  a_cls_thirty: assert property (exec_ok && (op == OP_CLS) |=>
    tx_valid && (tx_char == 8'h0d) && (tx_cnt_ff == 6'd30))
    else $error("clear screen count wrong");
  a_resume_gate: assert property (ctl.resume |->
    $past(prog_suspended) && !$past(prog_modified) && !$past(prog_finished))
    else $error("resume granted while not allowed");
  a_bad_cmd: assert property (wr_cmd && (verdict != ERR_NONE) |=>
    ctl.err && $stable(burst_ms) && $stable(tx_b8zs) && $stable(cab_w))
    else $error("rejected command changed a setting");

  c_cls_done: cover property (exec_ok && (op == OP_CLS) ##[1:60] tx_st_ff == TX_IDLE);
  c_burst_round: cover property (do_set && (op == OP_BURST) && (quant_ms != raw_ms));
  c_resume_ref: cover property (wr_cmd && (op == OP_RESUME) && !resume_ok);
  c_single_burst: cover property (set_ins && (ins_arg == INS_SINGLE) && (burst_ms != 16'h0000));
  c_alarm_print: cover property (ctl.alarm_print);
endmodule : rci_interp
`default_nettype wire

// >>> hw/rci_params.svh
// Constants of the remote command interpreter: offsets, codes, resets, timing
`ifndef RCI_PARAMS_SVH
`define RCI_PARAMS_SVH
`define RCI_OFF_CMD 8'h00
`define RCI_OFF_ARGA 8'h04
`define RCI_OFF_ARGB 8'h08
`define RCI_OFF_SEP 8'h0c
`define RCI_OFF_STAT 8'h10
`define RCI_OFF_SETS 8'h14
`define RCI_OFF_BURST 8'h18
`define RCI_OFF_TIME 8'h1c
`define RCI_OFF_DATE 8'h20
`define RCI_OFF_CABLE 8'h24
`define RCI_CMD_SET_BIT 8
`define RCI_BURST_MIN 16'd25
`define RCI_BURST_MAX 16'd5000
`define RCI_RST_BURST 16'd0
`define RCI_VEL_DEFAULT 7'd66
`define RCI_CLS_COUNT 6'd30
`define RCI_CHR_CR 8'h0d
`define RCI_CHR_BEL 8'h07
`define RCI_CLK_NS 4
`define RCI_SEC_NS 1000000000
`define RCI_TICK_CYC (`RCI_SEC_NS / `RCI_CLK_NS)
`endif

// >>> hw/rci_pkg.sv
// Types shared by the remote command interpreter
package rci_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ALARM = 5'h01, OP_BAUD = 5'h02, OP_BEEP = 5'h03,
    OP_BURST = 5'h04, OP_CABLE = 5'h05, OP_CLRFIFO = 5'h06, OP_CLOCK = 5'h07,
    OP_CLS = 5'h08, OP_CODE = 5'h09, OP_RESUME = 5'h0a, OP_CONTROLS = 5'h0b,
    OP_DBITS = 5'h0c, OP_DATE = 5'h0d, OP_DISHOLD = 5'h0e, OP_ERRINS = 5'h0f,
    OP_VEL = 5'h10
  } rci_op_e;
  typedef enum logic [2:0] {
    ERR_NONE = 3'h0, ERR_UNKNOWN = 3'h1, ERR_PARAM = 3'h2, ERR_RANGE = 3'h3,
    ERR_NOEXEC = 3'h4, ERR_RESUME = 3'h5, ERR_BUSY = 3'h6
  } rci_err_e;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} rci_tx_e;
  typedef enum logic [1:0] {INS_OFF = 2'h0, INS_RATE = 2'h1, INS_BURST = 2'h2,
    INS_SINGLE = 2'h3} rci_ins_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rci_bus_s;
  typedef struct packed {
    logic alarm_print;
    logic fifo_clear;
    logic resume;
    logic controls_print;
    logic err;
  } rci_ctl_s;
endpackage : rci_pkg

// >>> tb/rci_term.sv
// Terminal model that takes characters with random stalls and counts them
`timescale 1ns/1ns
`default_nettype none
`include "rci_params.svh"
module rci_term (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] tx_char, // Offered character
  input wire logic tx_valid, // Character offered
  output var logic tx_ready, // Take strobe
  output var int n_bel, // Bells taken
  output var int n_cr, // Returns taken
  output var int n_bad // Changes while stalled
);
  // ****
  // Receiver
  // ****
  logic held_ff;
  logic [7:0] last_ff;
  // Stalls about a third of the time so held characters get exercised
  always @(posedge ref_clk) begin
    tx_ready <= ($urandom % 3) != 0;
    held_ff <= tx_valid && !tx_ready;
    last_ff <= tx_char;
    if (sys_rst) begin
      n_bel <= 0;
      n_cr <= 0;
      n_bad <= 0;
    end else begin
      if (held_ff && tx_valid && tx_char !== last_ff) n_bad <= n_bad + 1;
      if (tx_valid && tx_ready && tx_char == `RCI_CHR_BEL) n_bel <= n_bel + 1;
      if (tx_valid && tx_ready && tx_char == `RCI_CHR_CR) n_cr <= n_cr + 1;
    end
  end
endmodule : rci_term
`default_nettype wire

// >>> tb/remote_command_interpreter_tb.sv
// Self-checking bench of the remote command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "rci_params.svh"
module remote_command_interpreter_tb;
  import rci_pkg::*;
  // ****
  // Harness
  // ****
  logic ref_clk, sys_rst, print_event_pin, alarm_msg_req, tx_ready, tx_valid, rx_b8zs;
  logic prog_suspended, prog_modified, prog_finished, tx_b8zs, display_freeze;
  logic [3:0] baud_code_pin, data_bits_pin;
  logic [31:0] rd_data, d;
  logic [7:0] tx_char;
  logic [2:0] err_code;
  logic [15:0] burst_ms;
  logic [6:0] propagation_velocity;
  rci_bus_s bus;
  rci_ctl_s ctl;
  rci_ins_e logic_ins, viol_ins;
  int fails, total_checks, cyc, cnt[5], n_bel, n_cr, n_bad, prev, e, ms, h, mi;
  string sp = ":,.;/-";
  int corner[8] = '{24, 5001, 25, 5000, 225, 575, 1999, 4999};
  rci_interp #(.TICK_CYC(20)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
    .rd_data(rd_data), .baud_code_pin(baud_code_pin), .data_bits_pin(data_bits_pin),
    .print_event_pin(print_event_pin), .alarm_msg_req(alarm_msg_req),
    .prog_suspended(prog_suspended), .prog_modified(prog_modified),
    .prog_finished(prog_finished), .tx_char(tx_char), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .ctl(ctl), .err_code(err_code), .tx_b8zs(tx_b8zs),
    .rx_b8zs(rx_b8zs), .display_freeze(display_freeze), .logic_ins(logic_ins),
    .viol_ins(viol_ins), .burst_ms(burst_ms), .propagation_velocity(propagation_velocity));
  rci_term term (.ref_clk(ref_clk), .sys_rst(sys_rst), .tx_char(tx_char),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .n_bel(n_bel), .n_cr(n_cr), .n_bad(n_bad));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Pulse counters, so a pulse landing a cycle late still counts once
  always @(posedge ref_clk) begin
    cyc++;
    for (int i = 0; i < 5; i++) cnt[i] += ctl[i];
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk);
    bus <= '{a, w, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rd_data;
  endtask : rd
  task cmd(input logic [4:0] op, input logic s, input logic [31:0] a, b, input logic [7:0] c);
    wr(`RCI_OFF_ARGA, a);
    wr(`RCI_OFF_ARGB, b);
    wr(`RCI_OFF_SEP, {24'h0, c});
    #1 cnt = '{default: 0};
    wr(`RCI_OFF_CMD, {23'h0, s, 3'h0, op});
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : cmd
  task idle;
    for (int i = 0; i < 400 && tx_valid !== 1'b0; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : idle
  task results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // Off-step values fall to the step below; -1 marks out of range
  function automatic int bexp(int m);
    if (m < 25 || m > 5000) return -1;
    if (m <= 200) return m / 25 * 25;
    if (m < 250) return 200;
    if (m <= 500) return m / 50 * 50;
    if (m < 600) return 500;
    if (m <= 1500) return m / 100 * 100;
    if (m < 2000) return 1500;
    return m / 500 * 500;
  endfunction : bexp
  // ****
  // Tests
  // ****
  initial begin
    sys_rst = 1'b1;
    bus = '0;
    alarm_msg_req = 1'b0;
    print_event_pin = 1'b0;
    {prog_suspended, prog_modified, prog_finished} = 3'h0;
    void'($urandom(32'h58ad));
    baud_code_pin = 4'($urandom);
    data_bits_pin = 4'($urandom);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`RCI_OFF_CABLE);
    chk("cable reset", d, 32'h00420204);
    rd(`RCI_OFF_DATE);
    chk("date reset", d, 32'h0101);
    wr(8'h84, 32'h1234);
    rd(8'h80);
    chk("unmapped", d, 0);
    rd(`RCI_OFF_BURST);
    chk("burst reset", d, 0);
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      ms = (i < 8) ? corner[i] : $urandom % 5200;
      e = bexp(ms);
      cmd(OP_BURST, 1, ms / 1000, ((ms / 100 % 10) << 12) | ((ms / 10 % 10) << 8)
        | ((ms % 10) << 4) | ($urandom % 10), 0);
      chk("burst err", cnt[0], e < 0);
      if (e < 0) chk("range code", err_code, ERR_RANGE);
      else prev = e;
      chk("burst", burst_ms, prev);
    end
    cmd(OP_BURST, 1, 0, 32'h0a00, 0);
    chk("param code", err_code, ERR_PARAM);
    cmd(5'h1f, 1, 0, 0, 0);
    chk("unknown code", err_code, ERR_UNKNOWN);
    chk("burst kept", burst_ms, prev);
    cmd(OP_NOP, 1, 0, 0, 0);
    chk("nop err", cnt[0], 0);
    for (int m = 0; m < 4; m++) for (int v = 0; v < 2; v++) begin
      cmd(OP_BURST, 1, 1, 0, 0);
      cmd(OP_ERRINS, 1, m, v, 0);
      chk("insert mode", v ? viol_ins : logic_ins, m);
      if (m == 3) chk("single zero", burst_ms, 0);
      else chk("burst held", burst_ms, 1000);
    end
    $display("test burst done");
    for (int i = 0; i < 6; i++) begin
      h = $urandom % 24;
      mi = $urandom % 60;
      cmd(OP_CLOCK, 1, h, mi, sp[i]);
      rd(`RCI_OFF_TIME);
      chk("time", d, (h << 16) | (mi << 8));
      e = 1 + $urandom % 31;
      ms = 1 + $urandom % 12;
      cmd(OP_DATE, 1, e, ms, sp[i]);
      rd(`RCI_OFF_DATE);
      chk("date", d, (e << 8) | ms);
    end
    cmd(OP_CLOCK, 1, (h + 1) % 24, mi, "x");
    chk("sep code", err_code, ERR_PARAM);
    cmd(OP_CLOCK, 1, 24, mi, ":");
    chk("hour err", cnt[0], 1);
    cmd(OP_CLOCK, 0, (h + 1) % 24, mi, ":");
    rd(`RCI_OFF_TIME);
    chk("time kept", d & 32'h1f3f00, (h << 16) | (mi << 8));
    cmd(OP_DATE, 1, e, 13, "/");
    rd(`RCI_OFF_DATE);
    chk("date kept", d, (e << 8) | ms);
    $display("test clock done");
    for (int t = 0; t < 4; t++) begin
      e = 2 + 2 * ($urandom % 3);
      cmd(OP_CABLE, 1, t, e, 0);
      rd(`RCI_OFF_CABLE);
      chk("cable", d[11:0], (e << 8) | t);
    end
    e = $urandom % 100;
    cmd(OP_VEL, 1, e, 0, 0);
    chk("velocity", propagation_velocity, e);
    cmd(OP_CABLE, 1, 4, 0, 0);
    rd(`RCI_OFF_CABLE);
    chk("default cable", d & 32'h7f0007, 32'h420004);
    for (int b = 1; b >= 0; b--) begin
      cmd(OP_CODE, 1, b, 0, 0);
      chk("tx code", tx_b8zs, b);
      chk("rx code", rx_b8zs, 1);
      cmd(OP_DISHOLD, 1, b, 0, 0);
      chk("freeze", display_freeze, b);
    end
    rd(`RCI_OFF_SETS);
    chk("serial", d[23:16], {data_bits_pin, baud_code_pin});
    cmd(OP_BAUD, 1, 32'(~baud_code_pin), 0, 0);
    chk("baud code", err_code, ERR_NOEXEC);
    cmd(OP_DBITS, 1, 32'(~data_bits_pin), 0, 0);
    chk("dbits code", err_code, ERR_NOEXEC);
    rd(`RCI_OFF_SETS);
    chk("serial kept", d[23:16], {data_bits_pin, baud_code_pin});
    $display("test settings done");
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      {prog_suspended, prog_modified, prog_finished} <= 3'(k);
      cmd(OP_RESUME, 0, 0, 0, 0);
      chk("resume", cnt[2], k == 4);
      if (k != 4) chk("resume code", err_code, ERR_RESUME);
    end
    cmd(OP_CLRFIFO, 0, 0, 0, 0);
    chk("fifo clear", cnt[3], 1);
    cmd(OP_CONTROLS, 0, 0, 0, 0);
    chk("controls", cnt[1], 1);
    for (int k = 0; k < 4; k++) begin
      cmd(OP_ALARM, 1, k % 2, 0, 0);
      @(posedge ref_clk);
      print_event_pin <= 1'(k / 2);
      repeat (5) @(posedge ref_clk);
      alarm_msg_req <= 1'b1;
      @(posedge ref_clk);
      alarm_msg_req <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk("alarm", cnt[4], k == 3);
    end
    $display("test actions done");
    e = n_bel;
    ms = n_cr;
    cmd(OP_BEEP, 0, 0, 0, 0);
    idle();
    chk("bell", n_bel - e, 1);
    cmd(OP_CLS, 0, 0, 0, 0);
    rd(`RCI_OFF_STAT);
    chk("busy", d[7], 1);
    cmd(OP_BEEP, 0, 0, 0, 0);
    chk("busy code", err_code, ERR_BUSY);
    idle();
    chk("returns", n_cr - ms, `RCI_CLS_COUNT);
    chk("bell kept", n_bel - e, 1);
    chk("held char", n_bad, 0);
    $display("test terminal done");
    results();
  end
endmodule : remote_command_interpreter_tb
`default_nettype wire
